// [core/tlbc_defs.svh]
`ifndef TLBC_DEFS_SVH
`define TLBC_DEFS_SVH

// Control word bit positions
`define TLBC_CTRL_XLATE_BIT   0
`define TLBC_CTRL_DCACHE_BIT  2
`define TLBC_CTRL_ICACHE_BIT  12

// Fault status codes: reset value and the code written when a lock walk aborts
`define TLBC_FSR_NONE         4'h0
`define TLBC_FSR_LOCK_ABORT   4'h4

// Index of the first entry and reset value of the lock pointer
`define TLBC_FIRST_ENTRY      0

// Translation lookaside buffer selectors
`define TLBC_ITLB             0
`define TLBC_DTLB             1
`define TLBC_NUM_TLB          2

`endif

// [core/tlbc_pkg.sv]
package tlbc_pkg;

  typedef enum logic [3:0] {
    OP_NOP,
    OP_CTRL_WR,
    OP_CTRL_RD,
    OP_INV_ALL,
    OP_INV_I,
    OP_INV_D,
    OP_INV_I_ENTRY,
    OP_INV_D_ENTRY,
    OP_LOCK_I,
    OP_LOCK_D,
    OP_UNLOCK_I,
    OP_UNLOCK_D,
    OP_WAIT
  } tlbc_op_e;

  typedef enum logic [0:0] {
    ST_IDLE,
    ST_WALK
  } tlbc_state_e;

endpackage

// [core/tlbc_ctrl.sv]
// Overview of operation
// R1: Data cache may be active only while address translation is on.
// R2: Instruction cache, data cache and translation enables are set independently.
// R3: Invalidate both buffers, either buffer, or one entry of either buffer.
// R4: Global invalidation keeps every locked entry intact and valid.
// R5: Entry invalidation of a locked entry leaves a hole until unlock.
// R6: Control word bit 0 written one enables translation, zero disables.
// R7: Translation off: instruction fetches cacheable, data accesses non-cacheable.
// R8: Translation enable takes effect before the wait sequence completes.
// R9: Coprocessor commands execute strictly in program order.
// R10: Lock translates the address and loads it locked into chosen buffer.
// R11: Software invalidates a resident translation before locking it.
// R12: Locked entries are excluded from hardware replacement.
// R13: Abort during lock records lock-abort fault and raises data abort.
// R14: Software masks both interrupt kinds during a lock sequence.
// R15: Software locks entries only in supervisor mode.
// R16: Round-robin victim pointer advances past the entry last written.
// R17: Round-robin pointer resets to 31, then moves to first unlocked.
// R18: Pointer steps sequentially to 31, then wraps to lowest unlocked.
// R19: Lock pointer resets to 0; lock writes at the lock pointer.
// R20: Successful lock advances lock pointer and forces round-robin to 31.
// R21: Only entries 0 to 30 are lockable; 31 never locks.
// R22: Lock at entry 31 writes unlocked and keeps round-robin at 31.
// R23: Each buffer has 32 entries and independent pointers.
`include "tlbc_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module tlbc_ctrl #(
  parameter int NE    = 32,
  parameter int VPN_W = 20,
  parameter int PPN_W = 20,
  parameter int PW    = $clog2(NE)
) (
  input  wire logic               clk,
  input  wire logic               nrst,
  input  wire logic               cmd_valid,
  input  wire tlbc_pkg::tlbc_op_e cmd_op,
  input  wire logic [31:0]        cmd_data,
  output logic                    cmd_ready,
  output logic                    cmd_done,
  output logic [31:0]             cmd_rdata,
  output logic                    walk_req,
  output logic [VPN_W-1:0]        walk_vpn,
  input  wire logic               walk_ack,
  input  wire logic               walk_abort,
  input  wire logic [PPN_W-1:0]   walk_ppn,
  input  wire logic               refill_i_valid,
  input  wire logic [VPN_W-1:0]   refill_i_vpn,
  input  wire logic [PPN_W-1:0]   refill_i_ppn,
  input  wire logic               refill_d_valid,
  input  wire logic [VPN_W-1:0]   refill_d_vpn,
  input  wire logic [PPN_W-1:0]   refill_d_ppn,
  input  wire logic [VPN_W-1:0]   lookup_i_vpn,
  input  wire logic [VPN_W-1:0]   lookup_d_vpn,
  output logic                    hit_i,
  output logic [PPN_W-1:0]        ppn_i,
  output logic                    hit_d,
  output logic [PPN_W-1:0]        ppn_d,
  output logic [PW-1:0]           rr_ptr_i,
  output logic [PW-1:0]           rr_ptr_d,
  output logic [PW-1:0]           lock_ptr_i,
  output logic [PW-1:0]           lock_ptr_d,
  output logic                    xlate_en,
  output logic                    icache_en,
  output logic                    dcache_active,
  output logic                    icache_cacheable,
  output logic                    data_uncacheable,
  output logic [3:0]              fault_status,
  output logic                    data_abort
);
  import tlbc_pkg::*;

  localparam logic [PW-1:0] LAST  = PW'(NE - 1);
  localparam logic [PW-1:0] FIRST = PW'(`TLBC_FIRST_ENTRY);

  initial begin
    if (NE != 32 || PW != 5) $error("tlbc_ctrl: exactly 32 entries per buffer are supported");
    if (VPN_W < 1 || VPN_W > 32) $error("tlbc_ctrl: VPN_W must be 1..32");
    if (PPN_W < 1) $error("tlbc_ctrl: PPN_W must be positive");
  end

  tlbc_state_e        st;
  logic               lock_tlb;
  logic [VPN_W-1:0]   lock_vpn;
  logic               ctrl_dcache;
  logic               busy_next;

  // Command decode
  wire               acc        = cmd_valid & cmd_ready;
  wire [VPN_W-1:0]   cmd_vpn    = cmd_data[31 -: VPN_W];
  wire               op_lock    = (cmd_op == OP_LOCK_I) | (cmd_op == OP_LOCK_D);
  wire               walk_end   = (st == ST_WALK) & walk_ack;
  wire               lock_ok    = walk_end & ~walk_abort;
  wire               ctrl_wr    = acc & (cmd_op == OP_CTRL_WR);
  wire               next_xlate = cmd_data[`TLBC_CTRL_XLATE_BIT];
  wire               next_dc    = cmd_data[`TLBC_CTRL_DCACHE_BIT];
  wire [31:0]        ctrl_word  = (32'h1 << `TLBC_CTRL_XLATE_BIT) & {32{xlate_en}}
                                | (32'h1 << `TLBC_CTRL_DCACHE_BIT) & {32{ctrl_dcache}}
                                | (32'h1 << `TLBC_CTRL_ICACHE_BIT) & {32{icache_en}};

  wire [`TLBC_NUM_TLB-1:0]  inv_all;
  wire [`TLBC_NUM_TLB-1:0]  inv_ent;
  wire [`TLBC_NUM_TLB-1:0]  unlock;
  wire [`TLBC_NUM_TLB-1:0]  commit;
  wire [`TLBC_NUM_TLB-1:0]  refill_v;
  wire [VPN_W-1:0]          refill_vpn [`TLBC_NUM_TLB];
  wire [PPN_W-1:0]          refill_ppn [`TLBC_NUM_TLB];
  wire [VPN_W-1:0]          lookup_vpn [`TLBC_NUM_TLB];
  logic                     lu_hit [`TLBC_NUM_TLB];
  logic [PPN_W-1:0]         lu_ppn [`TLBC_NUM_TLB];
  logic [PW-1:0]            rr     [`TLBC_NUM_TLB];
  logic [PW-1:0]            lp     [`TLBC_NUM_TLB];

  assign inv_all[`TLBC_ITLB] = acc & ((cmd_op == OP_INV_ALL) | (cmd_op == OP_INV_I)); // [R3]
  assign inv_all[`TLBC_DTLB] = acc & ((cmd_op == OP_INV_ALL) | (cmd_op == OP_INV_D)); // [R3]
  assign inv_ent[`TLBC_ITLB] = acc & (cmd_op == OP_INV_I_ENTRY); // [R3]
  assign inv_ent[`TLBC_DTLB] = acc & (cmd_op == OP_INV_D_ENTRY); // [R3]
  assign unlock[`TLBC_ITLB]  = acc & (cmd_op == OP_UNLOCK_I);
  assign unlock[`TLBC_DTLB]  = acc & (cmd_op == OP_UNLOCK_D);
  assign commit[`TLBC_ITLB]  = lock_ok & (lock_tlb == 1'(`TLBC_ITLB)); // [R10]
  assign commit[`TLBC_DTLB]  = lock_ok & (lock_tlb == 1'(`TLBC_DTLB)); // [R10]

  assign refill_v[`TLBC_ITLB]   = refill_i_valid;
  assign refill_v[`TLBC_DTLB]   = refill_d_valid;
  assign refill_vpn[`TLBC_ITLB] = refill_i_vpn;
  assign refill_vpn[`TLBC_DTLB] = refill_d_vpn;
  assign refill_ppn[`TLBC_ITLB] = refill_i_ppn;
  assign refill_ppn[`TLBC_DTLB] = refill_d_ppn;
  assign lookup_vpn[`TLBC_ITLB] = lookup_i_vpn;
  assign lookup_vpn[`TLBC_DTLB] = lookup_d_vpn;

  assign hit_i      = lu_hit[`TLBC_ITLB];
  assign ppn_i      = lu_ppn[`TLBC_ITLB];
  assign hit_d      = lu_hit[`TLBC_DTLB];
  assign ppn_d      = lu_ppn[`TLBC_DTLB];
  assign rr_ptr_i   = rr[`TLBC_ITLB];
  assign rr_ptr_d   = rr[`TLBC_DTLB];
  assign lock_ptr_i = lp[`TLBC_ITLB];
  assign lock_ptr_d = lp[`TLBC_DTLB];

  // One command in flight; a lock holds off the next until its walk ends
  assign busy_next = (st == ST_IDLE) ? (acc & op_lock) : ~walk_end; // [R9]

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st        <= ST_IDLE;
      cmd_ready <= 1'b0;
      cmd_done  <= 1'b0;
      cmd_rdata <= 32'h0;
      walk_req  <= 1'b0;
      walk_vpn  <= '0;
      lock_tlb  <= 1'b0;
      lock_vpn  <= '0;
    end else begin
      st        <= busy_next ? ST_WALK : ST_IDLE; // [R9]
      cmd_ready <= ~busy_next; // [R9]
      cmd_done  <= (acc & ~op_lock) | walk_end;
      if (acc & (cmd_op == OP_CTRL_RD)) begin
        cmd_rdata <= ctrl_word;
      end
      if (acc & op_lock) begin
        walk_req <= 1'b1; // [R10]
        walk_vpn <= cmd_vpn;
        lock_vpn <= cmd_vpn;
        lock_tlb <= (cmd_op == OP_LOCK_D);
      end else if (walk_end) begin
        walk_req <= 1'b0;
      end
    end
  end

  // Control word applied when its write executes, so it is in force
  // before any later wait command can complete
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      xlate_en         <= 1'b0;
      ctrl_dcache      <= 1'b0;
      icache_en        <= 1'b0;
      dcache_active    <= 1'b0;
      icache_cacheable <= 1'b1;
      data_uncacheable <= 1'b1;
    end else if (ctrl_wr) begin
      xlate_en         <= next_xlate; // [R6] [R8]
      ctrl_dcache      <= next_dc; // [R2]
      icache_en        <= cmd_data[`TLBC_CTRL_ICACHE_BIT]; // [R2]
      dcache_active    <= next_dc & next_xlate; // [R1]
      icache_cacheable <= ~next_xlate; // [R7]
      data_uncacheable <= ~next_xlate; // [R7]
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fault_status <= `TLBC_FSR_NONE;
      data_abort   <= 1'b0;
    end else begin
      data_abort <= walk_end & walk_abort; // [R13]
      if (walk_end & walk_abort) begin
        fault_status <= `TLBC_FSR_LOCK_ABORT; // [R13]
      end
    end
  end

  for (genvar t = 0; t < `TLBC_NUM_TLB; t++) begin : g_tlb
    wire [NE-1:0]     ent_valid;
    wire [NE-1:0]     ent_lock;
    wire [NE-1:0]     ent_hole;
    wire [NE-1:0]     cmd_match;
    wire [NE-1:0]     lu_match;
    wire [PPN_W-1:0]  ent_ppn [NE];
    wire              lp_last = (lp[t] == LAST);
    // A lock commit wins over a refill in the same cycle
    wire              fill    = refill_v[t] & ~commit[t];
    wire [PW-1:0]     wr_idx  = commit[t] ? lp[t] : rr[t];
    wire [VPN_W-1:0]  wr_vpn  = commit[t] ? lock_vpn : refill_vpn[t];
    wire [PPN_W-1:0]  wr_ppn  = commit[t] ? walk_ppn : refill_ppn[t];
    logic [PPN_W-1:0] sel_ppn;

    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        rr[t] <= LAST; // [R17] [R23]
        lp[t] <= FIRST; // [R19]
      end else if (commit[t]) begin
        rr[t] <= LAST; // [R20] [R22]
        if (!lp_last) begin
          lp[t] <= lp[t] + PW'(1); // [R20] [R21]
        end
      end else begin
        if (unlock[t]) begin
          lp[t] <= FIRST;
        end
        if (fill) begin
          // Locked entries sit below the lock pointer, so wrap lands on it
          rr[t] <= (rr[t] == LAST) ? lp[t] : rr[t] + PW'(1); // [R16] [R17] [R18] [R12]
        end
      end
    end

    for (genvar e = 0; e < NE; e++) begin : g_ent
      logic              v;
      logic              lk;
      logic              hl;
      logic [VPN_W-1:0]  vp;
      logic [PPN_W-1:0]  pp;
      wire               we = (commit[t] | fill) & (wr_idx == PW'(e));

      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          v  <= 1'b0;
          lk <= 1'b0;
          hl <= 1'b0;
          vp <= '0;
          pp <= '0;
        end else begin
          if (we) begin
            v  <= 1'b1; // [R10]
            lk <= commit[t] & ~lp_last; // [R21] [R22]
            hl <= 1'b0;
            vp <= wr_vpn;
            pp <= wr_ppn;
          end else if (unlock[t]) begin
            lk <= 1'b0;
            hl <= 1'b0;
            v  <= v & ~hl;
          end else if (inv_all[t] & ~lk) begin
            v  <= 1'b0; // [R4]
          end else if (inv_ent[t] & cmd_match[e]) begin
            v  <= lk; // [R5]
            hl <= lk; // [R5]
          end
        end
      end

      assign ent_valid[e] = v;
      assign ent_lock[e]  = lk;
      assign ent_hole[e]  = hl;
      assign ent_ppn[e]   = pp;
      assign cmd_match[e] = v & (vp == cmd_vpn);
      assign lu_match[e]  = v & ~hl & (vp == lookup_vpn[t]); // [R5]
    end

    always_comb begin
      sel_ppn = '0;
      for (int e = 0; e < NE; e++) begin
        sel_ppn = sel_ppn | (ent_ppn[e] & {PPN_W{lu_match[e]}});
      end
    end

    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        lu_hit[t] <= 1'b0;
        lu_ppn[t] <= '0;
      end else begin
        lu_hit[t] <= |lu_match;
        lu_ppn[t] <= sel_ppn;
      end
    end
  end

endmodule

`default_nettype wire

// [dv/tlbc_walk_model.sv]
`timescale 1ns/100ps
`default_nettype none
module tlbc_walk_model (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        walk_req,
  input  wire logic [19:0] walk_vpn,
  input  wire logic [3:0]  ack_delay,
  input  wire logic        abort_next,
  output logic             walk_ack,
  output logic             walk_abort,
  output logic [19:0]      walk_ppn
);
  logic [3:0] cnt;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      {walk_ack, walk_abort, walk_ppn, cnt} <= '0;
    end else if (walk_req && !walk_ack && cnt >= ack_delay) begin
      walk_ack   <= 1'h1;
      walk_abort <= abort_next;
      walk_ppn   <= walk_vpn ^ 20'h3c0f1;
    end else begin
      // Answer lines carry junk outside the ack cycle
      walk_ack   <= 1'h0;
      walk_abort <= ~walk_abort;
      walk_ppn   <= ~walk_ppn;
      cnt        <= (walk_req && !walk_ack) ? cnt + 4'h1 : 4'h0;
    end
  end
endmodule
`default_nettype wire

// [dv/tlbc_ctrl_monitor.sv]
`timescale 1ns/100ps
`default_nettype none
module tlbc_monitor #(
  parameter int NE = 32,
  parameter int PW = $clog2(NE)
) (
  input wire logic               clk,
  input wire logic               nrst,
  input wire logic               cmd_valid,
  input wire logic               cmd_ready,
  input wire tlbc_pkg::tlbc_op_e cmd_op,
  input wire logic [31:0]        cmd_data,
  input wire logic               walk_req,
  input wire logic               walk_ack,
  input wire logic               walk_abort,
  input wire logic               refill_i_valid,
  input wire logic               refill_d_valid,
  input wire logic [PW-1:0]      rr_ptr_i,
  input wire logic [PW-1:0]      rr_ptr_d,
  input wire logic [PW-1:0]      lock_ptr_i,
  input wire logic [PW-1:0]      lock_ptr_d,
  input wire logic               xlate_en,
  input wire logic               dcache_active,
  input wire logic               icache_cacheable,
  input wire logic               data_uncacheable,
  input wire logic [3:0]         fault_status,
  input wire logic               data_abort
);
  import tlbc_pkg::*;
  logic lk_d;
  wire  take = cmd_valid && cmd_ready;
  wire  cmt  = walk_req && walk_ack;
  wire  xbit = cmd_data[0];
  // Remembers which buffer the pending lock targets
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) lk_d <= 1'h0;
    else if (take) lk_d <= cmd_op == OP_LOCK_D;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  a_dcache_gated: assert property (dcache_active |-> xlate_en) else $error("dcache active, xlate off");
  a_xlate_write: assert property (take && cmd_op == OP_CTRL_WR |=> xlate_en == $past(xbit))
    else $error("xlate enable not taken from write");
  a_off_defaults: assert property (!xlate_en |-> icache_cacheable && data_uncacheable)
    else $error("cacheability wrong with xlate off");
  a_walk_blocks: assert property (walk_req |-> !cmd_ready) else $error("command taken during walk");
  a_lock_advance: assert property (cmt && !walk_abort && !lk_d && lock_ptr_i != '1 |=>
    lock_ptr_i == $past(lock_ptr_i) + 1'h1 && rr_ptr_i == '1) else $error("lock pointer step wrong");
  a_lock_last: assert property (cmt && !walk_abort && lk_d && lock_ptr_d == '1 |=>
    lock_ptr_d == '1 && rr_ptr_d == '1) else $error("lock at last entry wrong");
  a_abort_code: assert property (cmt && walk_abort |=> data_abort && fault_status == 4'h4 && $stable(lock_ptr_d))
    else $error("lock abort not reported");
  a_rr_wrap: assert property (refill_i_valid && rr_ptr_i == '1 && !(cmt && !lk_d) |=>
    rr_ptr_i == $past(lock_ptr_i)) else $error("round robin wrap wrong");
  a_rr_step: assert property (refill_d_valid && rr_ptr_d != '1 && !(cmt && lk_d) |=>
    rr_ptr_d == $past(rr_ptr_d) + 1'h1) else $error("round robin step wrong");
  c_lock: cover property (cmt && !walk_abort);
  c_abort: cover property (cmt && walk_abort);
  c_wrap: cover property (refill_i_valid && rr_ptr_i == '1);
endmodule
bind tlbc_ctrl tlbc_monitor #(.NE(NE), .PW(PW)) mon_u (.clk, .nrst, .cmd_valid, .cmd_ready, .cmd_op, .cmd_data,
  .walk_req, .walk_ack, .walk_abort, .refill_i_valid, .refill_d_valid, .rr_ptr_i, .rr_ptr_d, .lock_ptr_i,
  .lock_ptr_d, .xlate_en, .dcache_active, .icache_cacheable, .data_uncacheable, .fault_status, .data_abort);
`default_nettype wire

// [dv/testbench.sv]
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import tlbc_pkg::*;
  typedef struct {int s; logic [31:0] v;} tlbc_note_s;
  logic        clk, nrst, cmd_valid, refill_i_valid, refill_d_valid, abort_next, cmd_ready, cmd_done;
  logic        walk_req, walk_ack, walk_abort, hit_i, hit_d, data_abort, xlate_en, icache_en;
  logic        dcache_active, icache_cacheable, data_uncacheable;
  logic [31:0] cmd_data, cmd_rdata, ce;
  logic [19:0] walk_vpn, walk_ppn, refill_i_vpn, refill_i_ppn, refill_d_vpn, refill_d_ppn;
  logic [19:0] lookup_i_vpn, lookup_d_vpn, ppn_i, ppn_d;
  logic [4:0]  rr_ptr_i, rr_ptr_d, lock_ptr_i, lock_ptr_d, rr_i, lp_i, rr_d, lp_d;
  logic [3:0]  fault_status, ack_delay, flt;
  tlbc_op_e    cmd_op;
  tlbc_op_e    ro[3] = '{OP_CTRL_RD, OP_WAIT, OP_NOP};
  tlbc_note_s  q[$];
  int          error_cnt, samples_checked;
  wire [31:0]  ctl = 32'({xlate_en, icache_en, dcache_active, icache_cacheable, data_uncacheable});
  wire [31:0]  st = 32'({data_abort, lock_ptr_i, rr_ptr_i, lock_ptr_d, rr_ptr_d, fault_status});
  tlbc_ctrl dut_u (.clk, .nrst, .cmd_valid, .cmd_op, .cmd_data, .cmd_ready, .cmd_done, .cmd_rdata, .walk_req,
    .walk_vpn, .walk_ack, .walk_abort, .walk_ppn, .refill_i_valid, .refill_i_vpn, .refill_i_ppn, .refill_d_valid,
    .refill_d_vpn, .refill_d_ppn, .lookup_i_vpn, .lookup_d_vpn, .hit_i, .ppn_i, .hit_d, .ppn_d, .rr_ptr_i,
    .rr_ptr_d, .lock_ptr_i, .lock_ptr_d, .xlate_en, .icache_en, .dcache_active, .icache_cacheable,
    .data_uncacheable, .fault_status, .data_abort);
  tlbc_walk_model wm_u (.clk, .nrst, .walk_req, .walk_vpn, .ack_delay, .abort_next, .walk_ack, .walk_abort,
    .walk_ppn);
  always #2.5 clk = ~clk;
  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    samples_checked++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic rdy();
    for (int k = 0; cmd_ready !== 1'h1; k++) begin
      if (k > 99) begin
        chk("ready wait", 1, 0);
        final_report();
      end
      @(negedge clk);
    end
  endtask
  task automatic cmd(tlbc_op_e op, logic [31:0] d, int s, logic [31:0] e);
    @(negedge clk);
    cmd_valid = 1'h1;
    cmd_op = op;
    cmd_data = d;
    q.push_back('{s, e});
    rdy();
    @(posedge clk);
  endtask
  task automatic idle();
    @(negedge clk);
    cmd_valid = 1'h0;
    rdy();
    @(negedge clk);
  endtask
  task automatic look(bit d, logic [19:0] v, logic h, logic [19:0] p);
    @(negedge clk);
    lookup_i_vpn = v;
    lookup_d_vpn = v;
    @(negedge clk);
    chk("lookup", {h, h ? p : 20'h0}, d ? {hit_d, ppn_d & {20{hit_d}}} : {hit_i, ppn_i & {20{hit_i}}});
  endtask
  task automatic fill(bit d, logic [19:0] v);
    @(negedge clk);
    {refill_i_valid, refill_d_valid} = {!d, d};
    {refill_i_vpn, refill_d_vpn, refill_i_ppn, refill_d_ppn} = {v, v, ~v, ~v};
    @(negedge clk);
    {refill_i_valid, refill_d_valid} = 2'h0;
    if (d) rr_d = rr_d == 5'h1f ? lp_d : rr_d + 5'h1;
    else rr_i = rr_i == 5'h1f ? lp_i : rr_i + 5'h1;
    chk("round robin", {rr_i, rr_d}, {rr_ptr_i, rr_ptr_d});
  endtask
  task automatic lock(bit d, logic [19:0] v, bit ab);
    @(negedge clk);
    cmd_valid = 1'h0; // No other command mid-sequence
    rdy();
    abort_next = ab;
    ack_delay = 4'($urandom_range(0, 6));
    flt = ab ? 4'h4 : flt;
    if (!ab && d) {rr_d, lp_d} = {5'h1f, lp_d == 5'h1f ? lp_d : lp_d + 5'h1};
    if (!ab && !d) {rr_i, lp_i} = {5'h1f, lp_i == 5'h1f ? lp_i : lp_i + 5'h1};
    cmd(d ? OP_LOCK_D : OP_LOCK_I, {v, 12'h0}, 1, 32'({ab, lp_i, rr_i, lp_d, rr_d, flt}));
  endtask
  always @(negedge clk) begin
    tlbc_note_s n;
    if (cmd_done === 1'h1) begin
      if (q.size() == 0) begin
        chk("unexpected done", 0, 1);
      end else begin
        n = q.pop_front();
        chk(n.s ? "state" : "control", n.v, n.s ? st : ctl);
      end
    end
  end
  initial begin
    {clk, nrst, cmd_valid, refill_i_valid, refill_d_valid, abort_next} = 6'h0;
    {cmd_data, refill_i_vpn, refill_i_ppn, refill_d_vpn, refill_d_ppn, lookup_i_vpn, lookup_d_vpn} = '0;
    {ack_delay, flt, lp_i, lp_d, rr_i, rr_d, ce} = {18'h0, 10'h3ff, 32'h0};
    cmd_op = OP_NOP;
    error_cnt = 0;
    samples_checked = 0;
    void'($urandom(32'h9603));
    repeat (16) @(negedge clk);
    nrst = 1'h1;
    @(negedge clk);
    chk("reset state", 32'({1'h0, lp_i, rr_i, lp_d, rr_d, flt}), st);
    for (int m = 0; m < 8; m++) begin
      ce = 32'({m[0], m[2], m[1] & m[0], !m[0], !m[0]});
      cmd(OP_CTRL_WR, $urandom() & ~32'h1005 | 32'({m[2], 9'h0, m[1], 1'h0, m[0]}), 0, ce);
      cmd(ro[m % 3], $urandom(), 0, ce);
      if (m % 3 == 0) begin
        idle();
        chk("read data", 32'({m[2], 9'h0, m[1], 1'h0, m[0]}), cmd_rdata);
      end
    end
    $display("test control done");
    cmd(OP_INV_ALL, 0, 0, ce);
    for (int k = 0; k < 3; k++) lock(0, 20'h100 + 20'(k), 0);
    idle();
    for (int k = 0; k < 33; k++) fill(0, 20'h80000 + 20'(k));
    look(0, 20'h80020, 1, ~20'h80020);
    cmd(OP_INV_I, 0, 0, ce);
    cmd(OP_INV_I_ENTRY, {20'h101, 12'h0}, 0, ce);
    idle();
    look(0, 20'h80020, 0, 0);
    for (int k = 0; k < 3; k++) look(0, 20'h100 + 20'(k), k != 1, 20'h100 + 20'(k) ^ 20'h3c0f1);
    cmd(OP_UNLOCK_I, 0, 0, ce);
    lp_i = 5'h0;
    $display("test itlb done");
    cmd(OP_INV_D, 0, 0, ce);
    idle();
    fill(1, 20'h80100);
    fill(1, 20'h80101);
    for (int k = 0; k < 32; k++) lock(1, 20'h200 + 20'(k), 0);
    idle();
    look(1, 20'h21f, 1, 20'h21f ^ 20'h3c0f1);
    cmd(OP_INV_D_ENTRY, {20'h21f, 12'h0}, 0, ce);
    idle();
    look(1, 20'h21f, 0, 0);
    cmd(OP_UNLOCK_D, 0, 0, ce);
    lp_d = 5'h0;
    lock(1, 20'h300, 1);
    idle();
    look(1, 20'h300, 0, 0);
    $display("test dtlb done");
    final_report();
  end
endmodule
`default_nettype wire
